// >>> lodtc_pkg.sv
package lodtc_pkg;
   localparam int         ADDR_W        = 8;
   localparam logic [7:0] OFS_FEAT      = 8'h00;
   localparam logic [7:0] OFS_MATRIX    = 8'h04;
   localparam logic [7:0] OFS_CMD       = 8'h08;
   localparam logic [7:0] OFS_OWN       = 8'h0c;
   localparam logic [7:0] OFS_STAT      = 8'h10;
   localparam int         FEAT_SELF_BIT = 0;
   localparam int         CMD_VOL_LSB   = 0;
   localparam int         CMD_EXEC_BIT  = 8;
   localparam int         CMD_OUT_BIT   = 9;
   localparam int         CMD_BURST_BIT = 10;
   localparam int         MAP_LO_LSB    = 0;
   localparam int         MAP_HI_LSB    = 8;
   localparam int         DQ_LSB        = 16;
   localparam int         RE_LSB        = 24;
   localparam logic [3:0] RTT_150       = 4'h1;
   localparam logic [3:0] RTT_100       = 4'h2;
   localparam logic [3:0] RTT_75        = 4'h3;
   localparam logic [3:0] RTT_50        = 4'h4;
   localparam logic [7:0] OHMS_150      = 8'h96;
   localparam logic [7:0] OHMS_100      = 8'h64;
   localparam logic [7:0] OHMS_75       = 8'h4b;
   localparam logic [7:0] OHMS_50       = 8'h32;
   localparam logic [7:0] RST_BYTE      = 8'h00;
   localparam logic [3:0] RST_VOL       = 4'h0;
   localparam logic [2:0] DQS_HOLD_CYC  = 3'h4;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;
   typedef enum logic [1:0] {LODTC_DESEL, LODTC_SEL, LODTC_LISTEN} lodtc_state_t;
endpackage : lodtc_pkg

// >>> lodtc_sync.sv
module lodtc_sync #(
   parameter int W = 4
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   // Two-stage synchroniser; only the second stage is visible.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : lodtc_sync

// >>> lodtc_rtt_dec.sv
module lodtc_rtt_dec (
   input  wire logic [3:0] code,
   output logic            valid,
   output logic      [7:0] ohms
);
   // Maps a strength code to its resistance; unknown codes disable termination.
   always_comb begin
      valid = 1'b1;
      ohms  = lodtc_pkg::OHMS_150;
      unique case (code)
         lodtc_pkg::RTT_150 : ohms = lodtc_pkg::OHMS_150;
         lodtc_pkg::RTT_100 : ohms = lodtc_pkg::OHMS_100;
         lodtc_pkg::RTT_75  : ohms = lodtc_pkg::OHMS_75;
         lodtc_pkg::RTT_50  : ohms = lodtc_pkg::OHMS_50;
         default : begin
            valid = 1'b0;
            ohms  = 8'h00;
         end
      endcase
   end
endmodule : lodtc_rtt_dec

// >>> lodtc_top.sv
module lodtc_top (
   input  wire logic                         REF_CLK,
   input  wire logic                         RST_B,
   input  wire logic                         HSEL,
   input  wire logic [lodtc_pkg::ADDR_W-1:0] HADDR,
   input  wire logic [1:0]                   HTRANS,
   input  wire logic                         HWRITE,
   input  wire logic [2:0]                   HSIZE,
   input  wire logic [31:0]                  HWDATA,
   input  wire logic                         HREADY,
   output logic                              HREADYOUT,
   output logic                              HRESP,
   output logic      [31:0]                  HRDATA,
   input  wire logic                         ALE,
   input  wire logic                         CLE,
   input  wire logic                         DQS,
   input  wire logic                         RE_N,
   input  wire logic                         MATRIX_SEEN,
   output logic                              MATRIX_ISSUED,
   output logic      [1:0]                   LUN_STATE,
   output logic                              ODT_DQ_EN,
   output logic      [7:0]                   ODT_DQ_OHMS,
   output logic                              ODT_RE_EN,
   output logic      [7:0]                   ODT_RE_OHMS
);
   logic [3:0]                   pin_s;
   logic                         ale_s;
   logic                         cle_s;
   logic                         dqs_s;
   logic                         re_n_s;
   logic                         dqs_d_r;
   logic [2:0]                   dqs_hold_r;
   logic                         acc;
   logic                         wr_pend_r;
   logic [lodtc_pkg::ADDR_W-1:0] wr_addr_r;
   logic                         wr_feat;
   logic                         wr_matrix;
   logic                         wr_cmd;
   logic                         wr_own;
   logic [31:0]                  hrdata_r;
   logic                         self_en_r;
   logic                         matrix_mode_r;
   logic                         matrix_pulse_r;
   logic [7:0]                   map_lo_r;
   logic [7:0]                   map_hi_r;
   logic [7:0]                   dq_str_r;
   logic [7:0]                   re_str_r;
   logic [3:0]                   own_vol_r;
   logic [3:0]                   sel_vol_r;
   logic                         exec_r;
   logic                         dir_out_r;
   logic                         burst_r;
   logic [15:0]                  vol_map;
   logic                         is_term;
   logic [3:0]                   cmd_vol;
   lodtc_pkg::lodtc_state_t      state_r;
   lodtc_pkg::lodtc_state_t      state_nxt;
   logic                         sniff_act;
   logic                         sniff_out;
   logic                         use_out;
   logic                         dq_want;
   logic                         re_want;
   logic [3:0]                   dq_code;
   logic                         dq_ok;
   logic [7:0]                   dq_ohms;
   logic                         re_ok;
   logic [7:0]                   re_ohms;
   logic                         dq_en_r;
   logic [7:0]                   dq_ohms_r;
   logic                         re_en_r;
   logic [7:0]                   re_ohms_r;

   // Channel pins come from outside the clock domain.
   lodtc_sync #(.W (4)) u_sync (
      .clk   (REF_CLK),
      .rst_b (RST_B),
      .d     ({ALE, CLE, DQS, RE_N}),
      .q     (pin_s)
   );

   assign {ale_s, cle_s, dqs_s, re_n_s} = pin_s;

   // A DQS edge keeps the sniffed write burst alive for a few cycles.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         dqs_d_r    <= 1'b0;
         dqs_hold_r <= 3'h0;
      end else begin
         dqs_d_r <= dqs_s;
         if (dqs_s != dqs_d_r) begin
            dqs_hold_r <= lodtc_pkg::DQS_HOLD_CYC;
         end else if (dqs_hold_r != 3'h0) begin
            dqs_hold_r <= dqs_hold_r - 3'h1;
         end
      end
   end

   // Bus slave is always ready and always answers OKAY.
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;
   assign HRDATA    = hrdata_r;
   assign acc       = HSEL && HTRANS[1] && HREADY;

   // Word writes are captured in the address phase and applied in the data phase.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
      end else begin
         wr_pend_r <= acc && HWRITE && (HSIZE == lodtc_pkg::HSIZE_WORD);
         wr_addr_r <= HADDR;
      end
   end

   assign wr_feat   = wr_pend_r && (wr_addr_r == lodtc_pkg::OFS_FEAT);
   assign wr_matrix = wr_pend_r && (wr_addr_r == lodtc_pkg::OFS_MATRIX);
   assign wr_cmd    = wr_pend_r && (wr_addr_r == lodtc_pkg::OFS_CMD);
   assign wr_own    = wr_pend_r && (wr_addr_r == lodtc_pkg::OFS_OWN);

   // Read data is prepared at the address phase and stands in the data phase.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         hrdata_r <= 32'h0000_0000;
      end else if (acc && !HWRITE) begin
         unique case (HADDR)
            lodtc_pkg::OFS_FEAT   : hrdata_r <= {31'h0, self_en_r};
            lodtc_pkg::OFS_MATRIX : hrdata_r <= {re_str_r, dq_str_r, map_hi_r, map_lo_r};
            lodtc_pkg::OFS_CMD    : hrdata_r <= {21'h0, burst_r, dir_out_r, exec_r,
                                                 4'h0, sel_vol_r};
            lodtc_pkg::OFS_OWN    : hrdata_r <= {28'h0, own_vol_r};
            lodtc_pkg::OFS_STAT   : hrdata_r <= {8'h00, re_ohms_r, dq_ohms_r, 2'h0,
                                                 re_en_r, dq_en_r, self_en_r,
                                                 matrix_mode_r, state_r};
            default               : hrdata_r <= 32'h0000_0000;
         endcase
      end else begin
         hrdata_r <= 32'h0000_0000;
      end
   end

   // Self termination is latched only from the feature write.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         self_en_r <= 1'b0;
      end else if (wr_feat) begin
         self_en_r <= HWDATA[lodtc_pkg::FEAT_SELF_BIT];
      end
   end

   // Matrix configure here or on a sibling LUN moves the Target to matrix mode.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         matrix_mode_r  <= 1'b0;
         matrix_pulse_r <= 1'b0;
      end else begin
         matrix_pulse_r <= wr_matrix;
         if (wr_matrix || MATRIX_SEEN) begin
            matrix_mode_r <= 1'b1;
         end
      end
   end

   assign MATRIX_ISSUED = matrix_pulse_r;

   // Configuration matrix entry of this LUN.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         map_lo_r <= lodtc_pkg::RST_BYTE;
         map_hi_r <= lodtc_pkg::RST_BYTE;
         dq_str_r <= lodtc_pkg::RST_BYTE;
         re_str_r <= lodtc_pkg::RST_BYTE;
      end else if (wr_matrix) begin
         map_lo_r <= HWDATA[lodtc_pkg::MAP_LO_LSB +: 8];
         map_hi_r <= HWDATA[lodtc_pkg::MAP_HI_LSB +: 8];
         dq_str_r <= HWDATA[lodtc_pkg::DQ_LSB +: 8];
         re_str_r <= HWDATA[lodtc_pkg::RE_LSB +: 8];
      end
   end

   // Own volume address appointed at initialisation.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         own_vol_r <= lodtc_pkg::RST_VOL;
      end else if (wr_own) begin
         own_vol_r <= HWDATA[3:0];
      end
   end

   // Command context: addressed volume, execution, direction and burst.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         sel_vol_r <= lodtc_pkg::RST_VOL;
         exec_r    <= 1'b0;
         dir_out_r <= 1'b0;
         burst_r   <= 1'b0;
      end else if (wr_cmd) begin
         sel_vol_r <= cmd_vol;
         exec_r    <= HWDATA[lodtc_pkg::CMD_EXEC_BIT];
         dir_out_r <= HWDATA[lodtc_pkg::CMD_OUT_BIT];
         burst_r   <= HWDATA[lodtc_pkg::CMD_BURST_BIT];
      end
   end

   // Bit n of the bitmap marks volume n; bitmap and both strength bytes all zero means no terminator.
   assign vol_map = {map_hi_r, map_lo_r};
   assign is_term = |{vol_map, dq_str_r, re_str_r};
   assign cmd_vol = HWDATA[lodtc_pkg::CMD_VOL_LSB +: 4];

   // State follows the volume that each command addresses.
   always_comb begin
      state_nxt = state_r;
      if (wr_cmd) begin
         if (cmd_vol == own_vol_r) begin
            state_nxt = lodtc_pkg::LODTC_SEL;
         end else if (matrix_mode_r && is_term && vol_map[cmd_vol]) begin
            state_nxt = lodtc_pkg::LODTC_LISTEN;
         end else begin
            state_nxt = lodtc_pkg::LODTC_DESEL;
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_r <= lodtc_pkg::LODTC_DESEL;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign LUN_STATE = state_r;

   // Listening LUN sees only the latch, strobe and read enable pins.
   assign sniff_act = !ale_s && !cle_s && (!re_n_s || (dqs_hold_r != 3'h0));
   assign sniff_out = !re_n_s;

   // Decides whether to terminate now and in which direction.
   always_comb begin
      dq_want = 1'b0;
      use_out = dir_out_r;
      if (!matrix_mode_r) begin
         dq_want = self_en_r && exec_r && burst_r && (state_r == lodtc_pkg::LODTC_SEL);
      end else if (is_term) begin
         unique case (state_r)
            lodtc_pkg::LODTC_SEL : begin
               dq_want = burst_r && (exec_r || vol_map[sel_vol_r]);
            end
            lodtc_pkg::LODTC_LISTEN : begin
               dq_want = sniff_act;
               use_out = sniff_out;
            end
            lodtc_pkg::LODTC_DESEL  : dq_want = 1'b0;
         endcase
      end
   end

   // Read enable pair is terminated only while data flows out.
   assign re_want = dq_want && use_out;
   localparam logic [3:0] SELF_CODE = lodtc_pkg::RTT_150; // No strength byte exists in self mode.
   assign dq_code = !matrix_mode_r ? SELF_CODE :
                    (use_out ? dq_str_r[7:4] : dq_str_r[3:0]);

   lodtc_rtt_dec u_dq_dec (
      .code  (dq_code),
      .valid (dq_ok),
      .ohms  (dq_ohms)
   );

   lodtc_rtt_dec u_re_dec (
      .code  (re_str_r[3:0]),
      .valid (re_ok),
      .ohms  (re_ohms)
   );

   // Termination controls are registered before they leave the block.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         dq_en_r   <= 1'b0;
         dq_ohms_r <= 8'h00;
         re_en_r   <= 1'b0;
         re_ohms_r <= 8'h00;
      end else begin
         dq_en_r   <= dq_want && dq_ok;
         dq_ohms_r <= (dq_want && dq_ok) ? dq_ohms : 8'h00;
         re_en_r   <= re_want && re_ok;
         re_ohms_r <= (re_want && re_ok) ? re_ohms : 8'h00;
      end
   end

   assign ODT_DQ_EN   = dq_en_r;
   assign ODT_DQ_OHMS = dq_ohms_r;
   assign ODT_RE_EN   = re_en_r;
   assign ODT_RE_OHMS = re_ohms_r;

   // Once in matrix mode the Target never returns to self mode.
   property p_matrix_sticky;
      @(posedge REF_CLK) disable iff (!RST_B)
      (wr_matrix || MATRIX_SEEN) |=> matrix_mode_r [*4];
   endproperty
   a_matrix_sticky : assert property (p_matrix_sticky)
      else $error("Matrix mode not held after configure.");
   // Self enable changes only after a feature write.
   property p_self_src;
      @(posedge REF_CLK) disable iff (!RST_B)
      $changed(self_en_r) |-> $past(wr_feat);
   endproperty
   a_self_src : assert property (p_self_src)
      else $error("Self termination changed without feature write.");
   // A command to the own volume selects this LUN.
   property p_own_sel;
      @(posedge REF_CLK) disable iff (!RST_B)
      (wr_cmd && (cmd_vol == own_vol_r)) |=> (LUN_STATE == 2'(lodtc_pkg::LODTC_SEL));
   endproperty
   a_own_sel : assert property (p_own_sel)
      else $error("Own volume command did not select the LUN.");
   // An empty matrix entry never terminates in matrix mode.
   property p_no_term;
      @(posedge REF_CLK) disable iff (!RST_B)
      (matrix_mode_r && !is_term) |=> !ODT_DQ_EN && !ODT_RE_EN;
   endproperty
   a_no_term : assert property (p_no_term)
      else $error("Empty matrix entry enabled termination.");
   // A latch cycle seen on the pins ends listening termination.
   property p_sniff_off;
      @(posedge REF_CLK) disable iff (!RST_B)
      (state_r == lodtc_pkg::LODTC_LISTEN && (ale_s || cle_s)) |=> !ODT_DQ_EN;
   endproperty
   a_sniff_off : assert property (p_sniff_off)
      else $error("Listening LUN terminated during a latch cycle.");
   // Self mode executing LUN terminates its own burst.
   property p_self_on;
      @(posedge REF_CLK) disable iff (!RST_B)
      (!matrix_mode_r && self_en_r && exec_r && burst_r && dq_ok &&
       state_r == lodtc_pkg::LODTC_SEL) |=> ODT_DQ_EN;
   endproperty
   a_self_on : assert property (p_self_on)
      else $error("Executing LUN did not terminate in self mode.");
   // A helper on the selected volume terminates alongside the executor.
   property p_helper_on;
      @(posedge REF_CLK) disable iff (!RST_B)
      (matrix_mode_r && is_term && state_r == lodtc_pkg::LODTC_SEL && burst_r &&
       vol_map[sel_vol_r] && dq_ok) |=> ODT_DQ_EN;
   endproperty
   a_helper_on : assert property (p_helper_on)
      else $error("Helper LUN failed to terminate on selected volume.");
   // Without a burst a selected LUN ignores pin activity.
   property p_ctx_only;
      @(posedge REF_CLK) disable iff (!RST_B)
      (state_r == lodtc_pkg::LODTC_SEL && !burst_r) |=> !ODT_DQ_EN;
   endproperty
   a_ctx_only : assert property (p_ctx_only)
      else $error("Selected LUN terminated outside a burst.");
   // Output direction uses the upper nibble strength.
   property p_dir_pick;
      @(posedge REF_CLK) disable iff (!RST_B)
      (dq_want && use_out && dq_str_r[7:4] == lodtc_pkg::RTT_50) |=>
         ODT_DQ_EN && (ODT_DQ_OHMS == lodtc_pkg::OHMS_50);
   endproperty
   a_dir_pick : assert property (p_dir_pick)
      else $error("Output strength not applied.");
   // Read enable code 3 gives 75 Ohms while data flows out.
   property p_re_75;
      @(posedge REF_CLK) disable iff (!RST_B)
      (re_want && re_str_r[3:0] == lodtc_pkg::RTT_75) |=>
         ODT_RE_EN && (ODT_RE_OHMS == lodtc_pkg::OHMS_75);
   endproperty
   a_re_75 : assert property (p_re_75)
      else $error("Read enable strength not applied.");
endmodule : lodtc_top

// >>> lodtc_chan_model.sv
module lodtc_chan_model (
   input  wire logic clk,
   output logic      ale,
   output logic      cle,
   output logic      dqs,
   output logic      re_n
);
   timeunit 1ns;
   timeprecision 1ps;

   // The idle channel has both latches low, read enable high and a parked strobe.
   initial begin
      ale = 1'b0;
      cle = 1'b0;
      dqs = 1'b0;
      re_n = 1'b1;
   end

   // Read enable stays low for the whole of a data output phase.
   task automatic set_read(input logic on);
      @(posedge clk);
      re_n <= ~on;
   endtask : set_read

   // Address and command latch levels are driven for the cycles that follow.
   task automatic set_lat(input logic a, input logic c);
      @(posedge clk);
      ale <= a;
      cle <= c;
   endtask : set_lat

   // The strobe toggles once a cycle only inside a data input burst.
   task automatic strobe(input int n);
      repeat (n) begin
         @(posedge clk);
         dqs <= ~dqs;
      end
   endtask : strobe
endmodule : lodtc_chan_model

// >>> test_lun_odt_termination_control.sv
module test_lun_odt_termination_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        hsel = 1'b0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h0;
   logic [31:0] hwdata = 32'h0;
   logic        matrix_seen = 1'b0;
   logic        hreadyout, hresp, matrix_issued, dq_en, re_en;
   logic        ale, cle, dqs, re_n;
   logic [31:0] hrdata, rd;
   logic [1:0]  lun_state;
   logic [7:0]  dq_ohms, re_ohms;
   logic [7:0]  ohm_tab [6] = '{8'h00, lodtc_pkg::OHMS_150, lodtc_pkg::OHMS_100,
                                lodtc_pkg::OHMS_75, lodtc_pkg::OHMS_50, 8'h00};
   int          err_count = 0;
   int          compares = 0;

   // Free running 125 MHz clock.
   always #4 ref_clk = ~ref_clk;

   lodtc_top u_lodtc_top (
      .REF_CLK(ref_clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
      .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata),
      .ALE(ale), .CLE(cle), .DQS(dqs), .RE_N(re_n), .MATRIX_SEEN(matrix_seen),
      .MATRIX_ISSUED(matrix_issued), .LUN_STATE(lun_state), .ODT_DQ_EN(dq_en),
      .ODT_DQ_OHMS(dq_ohms), .ODT_RE_EN(re_en), .ODT_RE_OHMS(re_ohms)
   );

   lodtc_chan_model u_lodtc_chan_model (
      .clk(ref_clk), .ale(ale), .cle(cle), .dqs(dqs), .re_n(re_n)
   );

   // Prints the counts and the verdict, then stops the run.
   task automatic complete_run();
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run

   // Counts one comparison and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Waits for ready at a rising edge; a stuck bus ends the run.
   task automatic wait_rdy();
      for (int i = 0; i < 50; i++) begin
         @(posedge ref_clk);
         if (hreadyout === 1'b1) begin
            return;
         end
      end
      err_count++;
      $display("Error %0t bus wait timed out", $time);
      complete_run();
   endtask : wait_rdy

   // One single transfer, word sized unless sz says otherwise: address phase, then data phase; read data lands in rd.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d = 32'h0,
                      input logic [2:0] sz = lodtc_pkg::HSIZE_WORD);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= sz;
      haddr <= a;
      wait_rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask : bus

   // Lets n rising edges pass, then samples the termination outputs at the falling edge.
   task automatic pins(input int n, input logic [1:0] st, input logic [17:0] od);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({12'h0, lun_state, dq_en, dq_ohms, re_en, re_ohms}, {12'h0, st, od});
   endtask : pins

   // Issues a command context and checks state and termination two edges later.
   task automatic cmd(input logic [3:0] v, input logic ex, input logic o, input logic b,
                      input logic [1:0] st, input logic [17:0] od);
      bus(1'b1, lodtc_pkg::OFS_CMD, {21'h0, b, o, ex, 4'h0, v});
      pins(2, st, od);
   endtask : cmd

   task automatic do_reset();
      rst_b <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rst_b <= 1'b1;
   endtask : do_reset

   // Main sequence: self mode, matrix mode, listening on the channel, strength codes.
   initial begin
      do_reset();
      bus(1'b0, lodtc_pkg::OFS_STAT);
      chk(rd, 32'h0);
      bus(1'b1, 8'h20, 32'hffff_ffff);
      bus(1'b0, 8'h20);
      chk(rd, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      bus(1'b1, lodtc_pkg::OFS_FEAT, 32'h1, 3'h0);
      bus(1'b0, lodtc_pkg::OFS_FEAT);
      chk(rd, 32'h0);
      cmd(4'h0, 1'b1, 1'b1, 1'b1, 2'h1, 18'h0);
      bus(1'b1, lodtc_pkg::OFS_FEAT, 32'h1);
      bus(1'b0, lodtc_pkg::OFS_STAT);
      chk(rd, {16'h0000, lodtc_pkg::OHMS_150, 8'h19});
      @(posedge ref_clk);
      matrix_seen <= 1'b1;
      @(posedge ref_clk);
      matrix_seen <= 1'b0;
      bus(1'b0, lodtc_pkg::OFS_STAT);
      chk(rd, 32'h0000_000d);
      do_reset();
      bus(1'b0, lodtc_pkg::OFS_STAT);
      chk(rd, 32'h0);
      bus(1'b1, lodtc_pkg::OFS_OWN, 32'h0);
      bus(1'b1, lodtc_pkg::OFS_MATRIX, 32'h0342_000d);
      @(negedge ref_clk);
      chk({31'h0, matrix_issued}, 32'h1);
      @(negedge ref_clk);
      chk({31'h0, matrix_issued}, 32'h0);
      cmd(4'h0, 1'b0, 1'b1, 1'b1, 2'h1, {1'b1, lodtc_pkg::OHMS_50, 1'b1, lodtc_pkg::OHMS_75});
      cmd(4'h0, 1'b0, 1'b0, 1'b1, 2'h1, {1'b1, lodtc_pkg::OHMS_100, 9'h0});
      cmd(4'h0, 1'b0, 1'b0, 1'b0, 2'h1, 18'h0);
      cmd(4'h1, 1'b0, 1'b1, 1'b1, 2'h0, 18'h0);
      cmd(4'h2, 1'b0, 1'b1, 1'b1, 2'h2, 18'h0);
      // Listening: only the channel pins decide until the matrix entry is rewritten.
      u_lodtc_chan_model.set_read(1'b1);
      pins(3, 2'h2, {1'b1, lodtc_pkg::OHMS_50, 1'b1, lodtc_pkg::OHMS_75});
      u_lodtc_chan_model.set_lat(1'b1, 1'b0);
      pins(3, 2'h2, 18'h0);
      u_lodtc_chan_model.set_lat(1'b0, 1'b1);
      pins(3, 2'h2, 18'h0);
      u_lodtc_chan_model.set_lat(1'b0, 1'b0);
      u_lodtc_chan_model.set_read(1'b0);
      pins(3, 2'h2, 18'h0);
      fork
         u_lodtc_chan_model.strobe(10);
         pins(6, 2'h2, {1'b1, lodtc_pkg::OHMS_100, 9'h0});
      join
      pins(3, 2'h2, {1'b1, lodtc_pkg::OHMS_100, 9'h0});
      pins(6, 2'h2, 18'h0);
      bus(1'b1, lodtc_pkg::OFS_MATRIX, 32'h0);
      cmd(4'h0, 1'b1, 1'b1, 1'b1, 2'h1, 18'h0);
      bus(1'b1, lodtc_pkg::OFS_MATRIX, 32'h0142_000c);
      cmd(4'h0, 1'b1, 1'b1, 1'b1, 2'h1, {1'b1, lodtc_pkg::OHMS_50, 1'b1, lodtc_pkg::OHMS_150});
      cmd(4'h0, 1'b0, 1'b1, 1'b1, 2'h1, 18'h0);
      // Input strength codes 0 to 5, including two that are refused.
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, lodtc_pkg::OFS_MATRIX, {12'h0, 4'(i), 16'h0001});
         cmd(4'h0, 1'b1, 1'b0, 1'b1, 2'h1, {ohm_tab[i] != 8'h00, ohm_tab[i], 9'h0});
      end
      complete_run();
   end
endmodule : test_lun_odt_termination_control
